/* rtl/ffuse_regs.sv */
/*
 * Flash parameter, revision and fuse mirror registers.
 * Assumes fuse contents come from nonvolatile storage on FUSE_STORE and
 * that chip erase over a debug link arrives as a synchronous pulse.
 */
// Chosen here: strobed register access.
`timescale 1ns/1ps
module ffuse_regs
	import ffuse_pkg::*;
#(
	parameter logic [3:0]  PAGE_CODE = 4'h4,
	parameter logic [3:0]  CAP_CODE  = 4'h9,
	parameter logic [11:0] VERSION   = 12'h120, // Arbitrary value
	parameter logic [31:0] FUSE_INIT = FFUSE_LO_SHIPPED
)(
	// Clock and reset
	input  wire logic          CLK,
	input  wire logic          SRST,
	// Register port
	input  wire logic [7:0]    ADDR,
	input  wire logic [31:0]   WDATA,
	input  wire logic          WR,
	input  wire logic          RD,
	output logic      [31:0]   RDATA,
	// Nonvolatile side
	input  wire logic [31:0]   FUSE_STORE,
	input  wire logic          CHIP_ERASE,
	// User page stage and load
	input  wire logic [31:0]   USER_PAGE_WORD,
	output logic      [31:0]   USER_PAGE_LIVE,
	// Decoded settings
	output ffuse_decode_s      FUSE_SETTINGS
);

	// ==========================================================
	// Elaboration checks
	if (PAGE_CODE > FFUSE_PAGE_MAX) begin : g_bad_page
		$error("page code out of range");
	end
	if (CAP_CODE == FFUSE_CAP_RSVD) begin : g_bad_cap
		$error("capacity code reserved");
	end

	// ==========================================================
	// State
	ffuse_state_e  state_q;
	logic [31:0]   bank_lo_q;
	logic [31:0]   user_live_q;
	logic [31:0]   rdata_q;
	logic [31:0]   geom_w;
	logic [31:0]   rev_w;
	logic [31:0]   ctrl_w;
	logic [31:0]   decode_w;
	ffuse_fields_s fields_w;
	ffuse_decode_s dec_w;

	// Fuse mirror: load once after reset, erase on demand
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_q   <= FFUSE_ST_LOAD;
			bank_lo_q <= FUSE_INIT;
		end else begin
			case (state_q)
				FFUSE_ST_LOAD: begin
					// An erase in the load cycle must not be lost behind the load
					if (CHIP_ERASE) begin
						bank_lo_q <= FFUSE_LO_ERASED;
						state_q   <= FFUSE_ST_ERASE;
					end else begin
						bank_lo_q <= FUSE_STORE;
						state_q   <= FFUSE_ST_RUN;
					end
				end
				FFUSE_ST_RUN: begin
					if (CHIP_ERASE) begin
						bank_lo_q <= FFUSE_LO_ERASED;
						state_q   <= FFUSE_ST_ERASE;
					end
				end
				FFUSE_ST_ERASE: begin
					// Erased image holds until the next chip reset
					bank_lo_q <= FFUSE_LO_ERASED;
				end
				default: begin
					state_q <= FFUSE_ST_LOAD;
				end
			endcase
		end
	end

	// User page word only reaches consumers at reset release
	always_ff @(posedge CLK) begin
		if (SRST) begin
			user_live_q <= 32'hFFFF_FFFF;
		end else if (state_q == FFUSE_ST_LOAD) begin
			user_live_q <= USER_PAGE_WORD;
		end
	end

	// ==========================================================
	// Decode
	ffuse_decode i_ffuse_decode (
		.bank   (bank_lo_q),
		.fields (fields_w),
		.dec    (dec_w)
	);

	// ==========================================================
	// Read views
	always_comb begin
		geom_w = 32'h0000_0000;
		geom_w[FFUSE_PAGE_LSB +: 3] = PAGE_CODE[2:0];
		geom_w[FFUSE_CAP_LSB +: 4]  = CAP_CODE;
		rev_w = 32'h0000_0000;
		rev_w[11:0] = VERSION;
		rev_w[FFUSE_VARIANT_LSB +: 4] = FFUSE_VARIANT;
		ctrl_w = 32'h0000_0000;
		ctrl_w[1:0] = state_q;
		decode_w = {20'h0_0000, dec_w};
	end

	// Read data one cycle after the strobe; writes are ignored
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rdata_q <= 32'h0000_0000;
		end else if (RD) begin
			case (ADDR)
				FFUSE_OFS_GEOMETRY: rdata_q <= geom_w;
				FFUSE_OFS_REVISION: rdata_q <= rev_w;
				FFUSE_OFS_BANK_HI:  rdata_q <= FFUSE_HI_UNUSED;
				FFUSE_OFS_BANK_LO:  rdata_q <= bank_lo_q;
				FFUSE_OFS_CTRL:     rdata_q <= ctrl_w;
				FFUSE_OFS_DECODE:   rdata_q <= decode_w;
				default:            rdata_q <= FFUSE_RD_UNMAPPED;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	// WR and WDATA reach no storage at all
	logic unused_w;
	assign unused_w = WR ^ (^WDATA);

	assign RDATA          = rdata_q;
	assign USER_PAGE_LIVE = user_live_q;
	assign FUSE_SETTINGS  = dec_w;

endmodule : ffuse_regs

/* rtl/ffuse_pkg.sv */
/*
 * Package for the flash parameter and fuse mirror block: register offsets,
 * field positions, reset and default values, enumerations and carrier types.
 * Assumes a single 100 MHz clock domain and a plain register port.
 */
package ffuse_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] FFUSE_OFS_GEOMETRY = 8'h0C;
	localparam logic [7:0] FFUSE_OFS_REVISION = 8'h10;
	localparam logic [7:0] FFUSE_OFS_BANK_HI  = 8'h14;
	localparam logic [7:0] FFUSE_OFS_BANK_LO  = 8'h18;
	localparam logic [7:0] FFUSE_OFS_CTRL     = 8'h1C;
	localparam logic [7:0] FFUSE_OFS_DECODE   = 8'h20;

	// ==========================================================
	// Field positions
	localparam int FFUSE_CAP_LSB      = 0;
	localparam int FFUSE_PAGE_LSB     = 8;
	localparam int FFUSE_VARIANT_LSB  = 16;
	localparam int FFUSE_BROWNOUT_ENABLE_FUSE_LSB    = 30;
	localparam int FFUSE_BROWNOUT_HYSTERESIS_FUSE_BIT  = 29;
	localparam int FFUSE_BODLVL_HI    = 28;
	localparam int FFUSE_BODLVL_LO    = 24;
	localparam int FFUSE_BODLVL0_BIT  = 23;
	localparam int FFUSE_USER_PAGE_PROTECT_FUSE_BIT    = 22;
	localparam int FFUSE_SEC_LSB      = 20;
	localparam int FFUSE_BOOT_LSB     = 17;
	localparam int FFUSE_FETCH_BIT    = 16;
	localparam int FFUSE_LOCK_LSB     = 0;

	// ==========================================================
	// Values
	localparam logic [31:0] FFUSE_LO_SHIPPED = 32'hE07F_FFFF;
	localparam logic [31:0] FFUSE_LO_ERASED  = 32'h0FFF_FFFF;
	localparam logic [31:0] FFUSE_HI_UNUSED  = 32'hFFFF_FFFF;
	localparam logic [31:0] FFUSE_RD_UNMAPPED = 32'h0000_0000;
	localparam logic [3:0]  FFUSE_CAP_RSVD   = 4'hF;
	localparam logic [3:0]  FFUSE_VARIANT    = 4'h0;
	localparam logic [3:0]  FFUSE_PAGE_MAX   = 4'h7;
	localparam logic [5:0]  FFUSE_BODLVL_MIN = 6'h00;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		FFUSE_BOD_OFF_A   = 2'b00,
		FFUSE_BOD_RESET   = 2'b01,
		FFUSE_BOD_NORESET = 2'b10,
		FFUSE_BOD_OFF_B   = 2'b11
	} ffuse_brownout_enable_fuse_e;

	typedef enum logic [1:0] {
		FFUSE_ST_LOAD = 2'b00,
		FFUSE_ST_RUN  = 2'b01,
		FFUSE_ST_ERASE = 2'b11
	} ffuse_state_e;

	typedef struct packed {
		ffuse_brownout_enable_fuse_e brownout_enable_fuse;
		logic         bod_hyst;
		logic [5:0]   bod_level;
		logic         user_prot;
		logic [1:0]   security;
		logic [2:0]   boot_prot;
		logic         fetch_lock;
		logic [15:0]  region_lock;
	} ffuse_fields_s;

	typedef struct packed {
		logic        bod_on;
		logic        bod_rst;
		logic        bod_hyst;
		logic [5:0]  bod_level;
		logic        boot_prot_on;
		logic        fetch_locked;
		logic        any_region_locked;
	} ffuse_decode_s;

endpackage : ffuse_pkg

/* rtl/ffuse_decode.sv */
/*
 * Splits the lower fuse bank into its named fields and decodes the
 * settings that other modules consume. Purely combinational.
 * Assumes the bank value is already held in flip-flops upstream.
 */
`timescale 1ns/1ps
module ffuse_decode
	import ffuse_pkg::*;
(
	// Fuse bank
	input  wire logic [31:0]  bank,
	// Decoded view
	output ffuse_fields_s     fields,
	output ffuse_decode_s     dec
);

	// ==========================================================
	// Field split
	always_comb begin
		fields.brownout_enable_fuse       = ffuse_brownout_enable_fuse_e'(bank[FFUSE_BROWNOUT_ENABLE_FUSE_LSB +: 2]);
		fields.bod_hyst    = bank[FFUSE_BROWNOUT_HYSTERESIS_FUSE_BIT];
		fields.bod_level   = {bank[FFUSE_BODLVL_HI:FFUSE_BODLVL_LO],
			bank[FFUSE_BODLVL0_BIT]};
		fields.user_prot   = bank[FFUSE_USER_PAGE_PROTECT_FUSE_BIT];
		fields.security    = bank[FFUSE_SEC_LSB +: 2];
		fields.boot_prot   = bank[FFUSE_BOOT_LSB +: 3];
		fields.fetch_lock  = bank[FFUSE_FETCH_BIT];
		fields.region_lock = bank[FFUSE_LOCK_LSB +: 16];
	end

	// ==========================================================
	// Settings decode
	always_comb begin
		case (fields.brownout_enable_fuse)
			FFUSE_BOD_RESET: begin
				dec.bod_on  = 1'b1;
				dec.bod_rst = 1'b1;
			end
			FFUSE_BOD_NORESET: begin
				dec.bod_on  = 1'b1;
				dec.bod_rst = 1'b0;
			end
			default: begin
				dec.bod_on  = 1'b0;
				dec.bod_rst = 1'b0;
			end
		endcase
		dec.bod_hyst          = fields.bod_hyst;
		// Minimum code sits below power-on reset, so it never fires
		dec.bod_level         = fields.bod_level;
		dec.boot_prot_on      = (fields.boot_prot != 3'b111);
		dec.fetch_locked      = ~fields.fetch_lock;
		dec.any_region_locked = ~(&fields.region_lock);
	end

endmodule : ffuse_decode

/* tb/ffuse_properties.sv */
/* Port checker for the fuse mirror registers.
   Assumes binding to ffuse_regs, one clock, parameters handed on. */
`timescale 1ns/1ps
module ffuse_properties
	import ffuse_pkg::*;
#(
	parameter logic [3:0]  PAGE_CODE = 4'h4,
	parameter logic [3:0]  CAP_CODE  = 4'h9,
	parameter logic [11:0] VERSION   = 12'h120
)(
	// Clock and reset
	input wire logic          CLK,
	input wire logic          SRST,
	// Register port
	input wire logic [7:0]    ADDR,
	input wire logic          WR,
	input wire logic          RD,
	input wire logic [31:0]   RDATA,
	// Side ports
	input wire logic          CHIP_ERASE,
	input wire logic [31:0]   USER_PAGE_LIVE,
	input wire ffuse_decode_s FUSE_SETTINGS
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	sequence s_rd(logic [7:0] a); RD && ADDR == a; endsequence
	// Bank is reloaded on the first edge after reset, so skip reads there
	sequence s_rd_lo; s_rd(FFUSE_OFS_BANK_LO) ##0 !CHIP_ERASE && !$past(SRST); endsequence
	property p_geo; s_rd(FFUSE_OFS_GEOMETRY) |=> RDATA == {21'h0, PAGE_CODE[2:0], 4'h0, CAP_CODE};
	endproperty
	property p_rev; s_rd(FFUSE_OFS_REVISION) |=> RDATA == {12'h000, FFUSE_VARIANT, 4'h0, VERSION};
	endproperty
	property p_hi; s_rd(FFUSE_OFS_BANK_HI) |=> RDATA == FFUSE_HI_UNUSED; endproperty
	property p_erase; CHIP_ERASE ##[1:4] s_rd(FFUSE_OFS_BANK_LO) |=> RDATA == FFUSE_LO_ERASED;
	endproperty
	property p_wr; WR && !RD |=> RDATA == 32'h0000_0000 && $stable(USER_PAGE_LIVE); endproperty
	property p_live; !$past(SRST) |=> $stable(USER_PAGE_LIVE); endproperty
	property p_dec; s_rd_lo |=> FUSE_SETTINGS.bod_on == ^RDATA[31:30]
		&& FUSE_SETTINGS.bod_rst == (RDATA[31:30] == 2'b01)
		&& FUSE_SETTINGS.bod_hyst == RDATA[29] && FUSE_SETTINGS.bod_level == RDATA[28:23];
	endproperty
	property p_lock; s_rd_lo |=> FUSE_SETTINGS.boot_prot_on == (RDATA[19:17] != 3'b111)
		&& FUSE_SETTINGS.fetch_locked == !RDATA[16]
		&& FUSE_SETTINGS.any_region_locked == (RDATA[15:0] != 16'hFFFF);
	endproperty
	a_geo: assert property (p_geo) else $error("geometry read wrong");
	a_rev: assert property (p_rev) else $error("revision read wrong");
	a_hi: assert property (p_hi) else $error("upper bank read wrong");
	a_erase: assert property (p_erase) else $error("erased bank read wrong");
	a_wr: assert property (p_wr) else $error("write had an effect");
	a_live: assert property (p_live) else $error("user page changed without reset");
	a_dec: assert property (p_dec) else $error("brownout decode wrong");
	a_lock: assert property (p_lock) else $error("lock decode wrong");
endmodule : ffuse_properties

bind ffuse_regs ffuse_properties #(.PAGE_CODE(PAGE_CODE), .CAP_CODE(CAP_CODE), .VERSION(VERSION))
	i_ffuse_properties (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
	.CHIP_ERASE(CHIP_ERASE), .USER_PAGE_LIVE(USER_PAGE_LIVE), .FUSE_SETTINGS(FUSE_SETTINGS));

/* tb/ffuse_regs_tb_top.sv */
/* Self-checking bench for the fuse mirror registers.
   Assumes default parameters and the plain register port. */
`timescale 1ns/1ps
module ffuse_regs_tb_top import ffuse_pkg::*; ;
	logic          CLK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0, CHIP_ERASE = 1'b0;
	logic [7:0]    ADDR = 8'h00;
	logic [31:0]   WDATA = 32'h0000_0000, FUSE_STORE = 32'h0000_0000;
	logic [31:0]   USER_PAGE_WORD = 32'h0000_0000, RDATA, USER_PAGE_LIVE;
	ffuse_decode_s FUSE_SETTINGS;
	int            n_mismatch = 0, comparisons = 0;
	logic [31:0]   pat [4] = '{32'h2A5A_0001, 32'h5F81_FFFF, 32'hBFFE_7FFF, 32'hC000_0000};
	ffuse_regs i_ffuse_regs (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .FUSE_STORE(FUSE_STORE), .CHIP_ERASE(CHIP_ERASE),
		.USER_PAGE_WORD(USER_PAGE_WORD), .USER_PAGE_LIVE(USER_PAGE_LIVE),
		.FUSE_SETTINGS(FUSE_SETTINGS));
	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [11:0] exp_dec(input logic [31:0] b);
		return {^b[31:30], b[31:30] == 2'b01, b[29], b[28:23], b[19:17] != 3'b111, !b[16],
			b[15:0] != 16'hFFFF};
	endfunction : exp_dec
	task automatic dchk(input logic [31:0] b);
		chk({20'h0, FUSE_SETTINGS}, {20'h0, exp_dec(b)});
	endtask : dchk
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		#1 chk(RDATA, exp);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rst(input logic [31:0] s, input logic [31:0] u);
		@(posedge CLK);
		SRST <= 1'b1;
		FUSE_STORE <= s;
		USER_PAGE_WORD <= u;
		repeat (10) @(posedge CLK);
		SRST <= 1'b0;
		repeat (2) @(posedge CLK);
		#1 chk(USER_PAGE_LIVE, u);
	endtask : rst
	task automatic give_verdict();
		$display("counts: comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	// ==========================================================
	// Clock, watchdog, tests
	initial begin
		forever #5 CLK = ~CLK;
	end
	// Whole run is about a hundred cycles
	initial begin
		#50000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		rst(FFUSE_LO_SHIPPED, 32'h1234_5678);
		rd(FFUSE_OFS_GEOMETRY, 32'h0000_0409);
		rd(FFUSE_OFS_REVISION, 32'h0000_0120);
		rd(FFUSE_OFS_BANK_HI, 32'hFFFF_FFFF);
		rd(FFUSE_OFS_BANK_LO, 32'hE07F_FFFF);
		dchk(32'hE07F_FFFF);
		rd(FFUSE_OFS_CTRL, 32'h0000_0001);
		rd(FFUSE_OFS_DECODE, {20'h0_0000, exp_dec(FFUSE_LO_SHIPPED)});
		$display("test shipped done");
		wr(FFUSE_OFS_BANK_LO, 32'h0000_0000);
		wr(FFUSE_OFS_GEOMETRY, 32'h0000_0000);
		wr(FFUSE_OFS_REVISION, 32'h0000_0000);
		USER_PAGE_WORD <= 32'hA5A5_0F0F;
		rd(8'h00, 32'h0000_0000);
		rd(FFUSE_OFS_BANK_LO, 32'hE07F_FFFF);
		rd(FFUSE_OFS_GEOMETRY, 32'h0000_0409);
		rd(FFUSE_OFS_REVISION, 32'h0000_0120);
		chk(USER_PAGE_LIVE, 32'h1234_5678);
		$display("test writes done");
		// Every brownout enable code, with varied level and lock fields
		for (int i = 0; i < 4; i++) begin
			rst(pat[i], ~pat[i]);
			rd(FFUSE_OFS_BANK_LO, pat[i]);
			dchk(pat[i]);
		end
		$display("test fuse codes done");
		@(posedge CLK);
		CHIP_ERASE <= 1'b1;
		@(posedge CLK);
		CHIP_ERASE <= 1'b0;
		rd(FFUSE_OFS_BANK_LO, FFUSE_LO_ERASED);
		dchk(FFUSE_LO_ERASED);
		rd(FFUSE_OFS_CTRL, 32'h0000_0003);
		$display("test erase done");
		give_verdict();
	end
endmodule : ffuse_regs_tb_top
